// file: dsp_params.svh
// Offsets, field positions, reset values and timing counts of the stop/protection block
`ifndef DSP_PARAMS_SVH
`define DSP_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DSP_OFS_GLOBAL_CONFIG  7'h00
`define DSP_OFS_INPUT_STATUS   7'h04
`define DSP_OFS_DRIVER_CONFIG  7'h05
`define DSP_OFS_ENCODER_MODE   7'h2F
`define DSP_OFS_PROT_STATUS    7'h6F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSP_GC_QSC_ENA_BIT     15
`define DSP_GC_DRV_DIS_BIT     14
`define DSP_DC_FSR_LSB         0
`define DSP_DC_HS_EN_BIT       4
`define DSP_DC_HS_SRC_LSB      5
`define DSP_EM_QSC_ENC_BIT     11
`define DSP_IS_EXT_CLK_BIT     0
`define DSP_IS_TEMP_LSB        1
`define DSP_IS_ADC_EN_BIT      9
`define DSP_IS_QSC_BIT         15
`define DSP_PS_OT_BIT          0
`define DSP_PS_SHORT_A_BIT     1
`define DSP_PS_SHORT_B_BIT     2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSP_RST_GLOBAL_CONFIG  32'h0000_0000
`define DSP_RST_DRIVER_CONFIG  32'h0000_0003
`define DSP_RST_ENCODER_MODE   32'h0000_0800
`define DSP_RST_ADC_EN         1'b1

// ----------------------------------------
// Timing and counts
// ----------------------------------------
`define DSP_CLK_PERIOD_NS      4
`define DSP_SLEEP_FILT_NS      35000
`define DSP_SLEEP_FILT_CYC     ((`DSP_SLEEP_FILT_NS + `DSP_CLK_PERIOD_NS - 1) / `DSP_CLK_PERIOD_NS)
`define DSP_SHORT_RETRIES      2'd3

// ----------------------------------------
// Overcurrent thresholds in mA
// ----------------------------------------
`define DSP_OC_MA_FSR3         12'hBB8
`define DSP_OC_MA_FSR2         12'h8CA
`define DSP_OC_MA_FSR1         12'h5DC
`define DSP_OC_MA_FSR0         12'h2EE

`endif

// file: dsp_pkg.sv
// Types shared by the stop/protection block
`default_nettype none
package dsp_pkg;

	// Sleep pin filter states
	typedef enum logic [2:0] {
		SLP_AWAKE = 3'b001,
		SLP_LOW   = 3'b010,
		SLP_RESET = 3'b100
	} dsp_slp_state_t;

	// Hard stop trigger source
	typedef enum logic [1:0] {
		HS_BOTH_A = 2'b00,
		HS_LEFT   = 2'b01,
		HS_RIGHT  = 2'b10,
		HS_BOTH_B = 2'b11
	} dsp_hs_src_t;

	// Decoded control bits
	typedef struct packed {
		logic        qsc_ena;
		logic        drv_dis;
		logic        hs_enable;
		dsp_hs_src_t hs_src;
		logic [1:0]  full_scale_range;
		logic        qsc_enc_en;
		logic        adc_en;
	} dsp_ctrl_t;

	// Protection status bits
	typedef struct packed {
		logic ot;
		logic short_a;
		logic short_b;
		logic qsc;
		logic ext_clk;
	} dsp_stat_t;

endpackage
`default_nettype wire

// file: dsp_sleep_filter.sv
// Sleep pin synchroniser and low-pulse filter
`default_nettype none
`include "dsp_params.svh"
module dsp_sleep_filter #(
	parameter int unsigned FILT_CYC = `DSP_SLEEP_FILT_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic sleep_pin_n,
	output var  logic chip_rst
);

	logic                   sync1_r;
	logic                   sync2_r;
	logic [15:0]            cnt_r;
	dsp_pkg::dsp_slp_state_t st_r;

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	// two-flop sync
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= sleep_pin_n;
			sync2_r <= sync1_r;
		end
	end

	// ----------------------------------------
	// Filter
	// ----------------------------------------
	// long low resets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r  <= dsp_pkg::SLP_AWAKE;
			cnt_r <= 16'h0000;
		end else begin
			case (st_r)
				dsp_pkg::SLP_AWAKE: begin
					cnt_r <= 16'h0001;
					if (!sync2_r) begin
						st_r <= dsp_pkg::SLP_LOW;
					end
				end
				dsp_pkg::SLP_LOW: begin
					cnt_r <= cnt_r + 16'h0001;
					if (sync2_r) begin
						st_r <= dsp_pkg::SLP_AWAKE;
					end else if (cnt_r >= 16'(FILT_CYC)) begin
						st_r <= dsp_pkg::SLP_RESET;
					end
				end
				dsp_pkg::SLP_RESET: begin
					if (sync2_r) begin
						st_r <= dsp_pkg::SLP_AWAKE;
					end
				end
				default: begin
					st_r <= dsp_pkg::SLP_AWAKE;
				end
			endcase
		end
	end

	assign chip_rst = (st_r == dsp_pkg::SLP_RESET);

endmodule
`default_nettype wire

// file: dsp_stop_ctrl.sv
// Bridge stop, quiescence, sleep, clock and protection supervisor
`default_nettype none
`include "dsp_params.svh"
module dsp_stop_ctrl #(
	parameter int unsigned SLEEP_FILT_CYC = `DSP_SLEEP_FILT_CYC
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// Control pins
	input  wire logic        SLEEP_PIN_N,
	input  wire logic        LEFT_REFERENCE_INPUT,
	input  wire logic        RIGHT_REFERENCE_INPUT,
	// Clock detector
	input  wire logic        EXT_CLK_PRESENT,
	output logic             CLK_SEL_EXT,
	// Analog monitors
	input  wire logic        TEMP_ABOVE_HIGH,
	input  wire logic        TEMP_BELOW_LOW,
	input  wire logic [7:0]  TEMP_CODE,
	input  wire logic        TEMP_CODE_VALID,
	input  wire logic [1:0]  SHORT_DETECT,
	input  wire logic        SHORT_CHECK,
	// Register port
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [6:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	output logic [31:0]      REG_RDATA,
	output logic             REG_RVALID,
	// Power stage and status
	output logic             BRIDGE_A_EN,
	output logic             BRIDGE_B_EN,
	output logic             ENCODER_EN,
	output logic             ADC_EN,
	output logic             SUPPLY_OFF,
	output logic             DIAG_RESET,
	output logic [11:0]      OC_THRESHOLD_MA
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic hs_hit(input dsp_pkg::dsp_hs_src_t src,
					input logic l, input logic r);
		case (src)
			dsp_pkg::HS_LEFT:  hs_hit = l;
			dsp_pkg::HS_RIGHT: hs_hit = r;
			default:           hs_hit = l & r;
		endcase
	endfunction

	function automatic logic [11:0] oc_ma(input logic [1:0] full_scale_range);
		case (full_scale_range)
			2'b11:   oc_ma = `DSP_OC_MA_FSR3;
			2'b10:   oc_ma = `DSP_OC_MA_FSR2;
			2'b01:   oc_ma = `DSP_OC_MA_FSR1;
			default: oc_ma = `DSP_OC_MA_FSR0;
		endcase
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic             chip_rst;
	logic             left_reference_input_s1_r;
	logic             left_reference_input_s2_r;
	logic             right_reference_input_s1_r;
	logic             right_reference_input_s2_r;
	logic             extc_s1_r;
	logic             extc_s2_r;
	logic [31:0]      global_config_r;
	logic [31:0]      dconf_r;
	logic [31:0]      encm_r;
	logic             adc_en_r;
	logic [7:0]       temp_r;
	logic             ot_r;
	logic [1:0]       short_r;
	logic [1:0]       retry_a_r;
	logic [1:0]       retry_b_r;
	logic             bra_r;
	logic             brb_r;
	logic             clk_ext_r;
	logic [31:0]      rdata_r;
	logic             rvalid_r;
	logic             wr_ok;
	logic             hard_stop;
	logic             stage_off;
	logic [31:0]      rd_nxt;
	dsp_pkg::dsp_ctrl_t ctrl;
	dsp_pkg::dsp_stat_t stat;

	// ----------------------------------------
	// Sleep filter
	// ----------------------------------------
	dsp_sleep_filter #(
		.FILT_CYC (SLEEP_FILT_CYC)
	) u_sleep (
		.clk         (CLK),
		.rst_n       (RST_N),
		.sleep_pin_n (SLEEP_PIN_N),
		.chip_rst    (chip_rst)
	);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// references synchronised
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			left_reference_input_s1_r <= 1'b0;
			left_reference_input_s2_r <= 1'b0;
			right_reference_input_s1_r <= 1'b0;
			right_reference_input_s2_r <= 1'b0;
			extc_s1_r <= 1'b0;
			extc_s2_r <= 1'b0;
		end else begin
			left_reference_input_s1_r <= LEFT_REFERENCE_INPUT;
			left_reference_input_s2_r <= left_reference_input_s1_r;
			right_reference_input_s1_r <= RIGHT_REFERENCE_INPUT;
			right_reference_input_s2_r <= right_reference_input_s1_r;
			extc_s1_r <= EXT_CLK_PRESENT;
			extc_s2_r <= extc_s1_r;
		end
	end

	// ----------------------------------------
	// Control decode
	// ----------------------------------------
	always_comb begin
		ctrl.qsc_ena    = global_config_r[`DSP_GC_QSC_ENA_BIT];
		ctrl.drv_dis    = global_config_r[`DSP_GC_DRV_DIS_BIT];
		ctrl.hs_enable  = dconf_r[`DSP_DC_HS_EN_BIT];
		ctrl.hs_src     = dsp_pkg::dsp_hs_src_t'(dconf_r[`DSP_DC_HS_SRC_LSB +: 2]);
		ctrl.full_scale_range        = dconf_r[`DSP_DC_FSR_LSB +: 2];
		ctrl.qsc_enc_en = encm_r[`DSP_EM_QSC_ENC_BIT];
		ctrl.adc_en     = adc_en_r;
	end

	// Serial interface is dead while the chip is held in reset
	assign wr_ok = REG_WR && !chip_rst;

	assign hard_stop = ctrl.hs_enable && hs_hit(ctrl.hs_src, left_reference_input_s2_r, right_reference_input_s2_r);

	assign stage_off = chip_rst || ctrl.drv_dis || ctrl.qsc_ena || hard_stop || ot_r;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// sleep reset restores defaults
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			global_config_r <= `DSP_RST_GLOBAL_CONFIG;
		end else if (chip_rst) begin
			global_config_r <= `DSP_RST_GLOBAL_CONFIG;
		end else begin
			if (wr_ok && REG_ADDR == `DSP_OFS_GLOBAL_CONFIG) begin
				global_config_r <= REG_WDATA;
			end
			// bridges stay off until a later write clears the disable bit
			if (ctrl.qsc_ena) begin
				global_config_r[`DSP_GC_DRV_DIS_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			dconf_r <= `DSP_RST_DRIVER_CONFIG;
			encm_r  <= `DSP_RST_ENCODER_MODE;
			adc_en_r <= `DSP_RST_ADC_EN;
		end else if (chip_rst) begin
			dconf_r <= `DSP_RST_DRIVER_CONFIG;
			encm_r  <= `DSP_RST_ENCODER_MODE;
			adc_en_r <= `DSP_RST_ADC_EN;
		end else if (wr_ok) begin
			if (REG_ADDR == `DSP_OFS_DRIVER_CONFIG) begin
				dconf_r <= REG_WDATA;
			end
			if (REG_ADDR == `DSP_OFS_ENCODER_MODE) begin
				encm_r <= REG_WDATA;
			end
			if (REG_ADDR == `DSP_OFS_INPUT_STATUS) begin
				adc_en_r <= REG_WDATA[`DSP_IS_ADC_EN_BIT];
			end
		end
	end

	// ----------------------------------------
	// Temperature
	// ----------------------------------------
	// latest temperature code captured while the ADC is enabled
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			temp_r <= 8'h00;
		end else if (chip_rst) begin
			temp_r <= 8'h00;
		end else if (adc_en_r && TEMP_CODE_VALID) begin
			temp_r <= TEMP_CODE;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ot_r <= 1'b0;
		end else if (TEMP_ABOVE_HIGH) begin
			ot_r <= 1'b1;
		end else if (TEMP_BELOW_LOW) begin
			ot_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Short protection
	// ----------------------------------------
	// retry counting per bridge
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			retry_a_r <= 2'd0;
			retry_b_r <= 2'd0;
		end else if (chip_rst || ctrl.drv_dis) begin
			retry_a_r <= 2'd0;
			retry_b_r <= 2'd0;
		end else if (SHORT_CHECK) begin
			retry_a_r <= SHORT_DETECT[0] ?
				retry_a_r + ((retry_a_r == `DSP_SHORT_RETRIES) ? 2'd0 : 2'd1) : 2'd0;
			retry_b_r <= SHORT_DETECT[1] ?
				retry_b_r + ((retry_b_r == `DSP_SHORT_RETRIES) ? 2'd0 : 2'd1) : 2'd0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			short_r <= 2'b00;
		end else if (chip_rst) begin
			short_r <= 2'b00;
		end else begin
			if (SHORT_CHECK && SHORT_DETECT[0] && retry_a_r == `DSP_SHORT_RETRIES) begin
				short_r[0] <= 1'b1;
			end else if (ctrl.drv_dis) begin
				short_r[0] <= 1'b0;
			end
			if (SHORT_CHECK && SHORT_DETECT[1] && retry_b_r == `DSP_SHORT_RETRIES) begin
				short_r[1] <= 1'b1;
			end else if (ctrl.drv_dis) begin
				short_r[1] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Bridge enables and clock select
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bra_r <= 1'b0;
			brb_r <= 1'b0;
		end else begin
			bra_r <= !stage_off && !short_r[0];
			brb_r <= !stage_off && !short_r[1];
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			clk_ext_r <= 1'b0;
		end else begin
			clk_ext_r <= extc_s2_r && !ctrl.qsc_ena && !chip_rst;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		stat.ot      = ot_r;
		stat.short_a = short_r[0];
		stat.short_b = short_r[1];
		stat.qsc     = ctrl.qsc_ena;
		stat.ext_clk = clk_ext_r;
		rd_nxt       = 32'h0000_0000;
		case (REG_ADDR)
			`DSP_OFS_GLOBAL_CONFIG: rd_nxt = global_config_r;
			`DSP_OFS_DRIVER_CONFIG: rd_nxt = dconf_r;
			`DSP_OFS_ENCODER_MODE:  rd_nxt = encm_r;
			`DSP_OFS_INPUT_STATUS: begin
				rd_nxt[`DSP_IS_EXT_CLK_BIT]       = stat.ext_clk;
				rd_nxt[`DSP_IS_TEMP_LSB +: 8]     = temp_r;
				rd_nxt[`DSP_IS_ADC_EN_BIT]        = ctrl.adc_en;
				rd_nxt[`DSP_IS_QSC_BIT]           = stat.qsc;
			end
			`DSP_OFS_PROT_STATUS: begin
				rd_nxt[`DSP_PS_OT_BIT]      = stat.ot;
				rd_nxt[`DSP_PS_SHORT_A_BIT] = stat.short_a;
				rd_nxt[`DSP_PS_SHORT_B_BIT] = stat.short_b;
			end
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r  <= 32'h0000_0000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= REG_RD && !chip_rst;
			if (REG_RD && !chip_rst) begin
				rdata_r <= rd_nxt;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign BRIDGE_A_EN     = bra_r;
	assign BRIDGE_B_EN     = brb_r;
	assign CLK_SEL_EXT     = clk_ext_r;
	// encoder kept in quiescence by default
	assign ENCODER_EN      = !chip_rst && (!ctrl.qsc_ena || ctrl.qsc_enc_en);
	assign ADC_EN          = ctrl.adc_en && !ctrl.qsc_ena && !chip_rst;
	assign SUPPLY_OFF      = chip_rst;
	assign DIAG_RESET      = chip_rst;
	assign OC_THRESHOLD_MA = oc_ma(ctrl.full_scale_range);
	assign REG_RDATA       = rdata_r;
	assign REG_RVALID      = rvalid_r;

endmodule
`default_nettype wire

// file: dsp_stop_ctrl_assertions.sv
// Assertion checker for the stop/protection supervisor
`default_nettype none
module dsp_stop_ctrl_assertions #(
	parameter int unsigned SLEEP_FILT_CYC = 20
) (
	// Clock, reset and pins
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        SLEEP_PIN_N,
	input wire logic        LEFT_REFERENCE_INPUT,
	input wire logic        RIGHT_REFERENCE_INPUT,
	input wire logic        EXT_CLK_PRESENT,
	input wire logic        TEMP_ABOVE_HIGH,
	// Register port
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [6:0]  REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic        REG_RVALID,
	// Outputs
	input wire logic        CLK_SEL_EXT,
	input wire logic        BRIDGE_A_EN,
	input wire logic        BRIDGE_B_EN,
	input wire logic        DIAG_RESET,
	input wire logic        SUPPLY_OFF,
	input wire logic [11:0] OC_THRESHOLD_MA
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ----------------------------------------
	// Shadow of control fields
	// ----------------------------------------
	logic [1:0]  fsr_r;
	logic [2:0]  hs_r;
	logic        qsc_r;
	logic        dis_r;
	logic        wr_ok;
	logic        trip;
	int unsigned low_r;
	assign wr_ok = REG_WR && !DIAG_RESET;
	assign trip  = hs_r[2] && (hs_r[1:0] == 2'h1 ? LEFT_REFERENCE_INPUT :
		hs_r[1:0] == 2'h2 ? RIGHT_REFERENCE_INPUT : LEFT_REFERENCE_INPUT && RIGHT_REFERENCE_INPUT);
	// Enable bit sits above the two source bits in hs_r
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			fsr_r <= 2'h3;
			hs_r  <= 3'h0;
			qsc_r <= 1'b0;
			dis_r <= 1'b0;
		end else if (DIAG_RESET) begin
			fsr_r <= 2'h3;
			hs_r  <= 3'h0;
			qsc_r <= 1'b0;
			dis_r <= 1'b0;
		end else begin
			if (wr_ok && REG_ADDR == 7'h05) begin
				fsr_r <= REG_WDATA[1:0];
				hs_r  <= {REG_WDATA[4], REG_WDATA[6:5]};
			end
			if (wr_ok && REG_ADDR == 7'h00) begin
				qsc_r <= REG_WDATA[15];
				dis_r <= REG_WDATA[14];
			end
			if (qsc_r) begin
				dis_r <= 1'b1;
			end
		end
	end
	// Length of the current low run on the sleep pin
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			low_r <= 0;
		end else if (SLEEP_PIN_N) begin
			low_r <= 0;
		end else begin
			low_r <= low_r + 1;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_off;
		!BRIDGE_A_EN && !BRIDGE_B_EN;
	endsequence
	sequence s_trip;
		trip;
	endsequence
	a_hard_stop_kill: assert property (s_trip [*4] |=> s_off)
		else $error("bridges on during hard stop");
	a_disable_kills: assert property ((qsc_r || dis_r) [*2] |=> s_off)
		else $error("bridges on while disabled");
	a_qsc_int_clk: assert property (qsc_r |=> !CLK_SEL_EXT)
		else $error("external clock kept in quiescence");
	a_ext_clk_follow: assert property ((EXT_CLK_PRESENT && !qsc_r && !DIAG_RESET) [*5]
		|-> CLK_SEL_EXT)
		else $error("external clock not taken");
	a_int_clk_fallback: assert property (!EXT_CLK_PRESENT [*5] |-> !CLK_SEL_EXT)
		else $error("no fallback to internal clock");
	a_fsr_threshold: assert property (OC_THRESHOLD_MA == (fsr_r == 2'h3 ? 12'hBB8 :
		fsr_r == 2'h2 ? 12'h8CA : fsr_r == 2'h1 ? 12'h5DC : 12'h2EE))
		else $error("overcurrent threshold wrong");
	a_sleep_not_early: assert property ($rose(DIAG_RESET) |-> low_r >= SLEEP_FILT_CYC)
		else $error("short sleep pulse caused reset");
	a_sleep_enters: assert property (low_r == SLEEP_FILT_CYC + 8 |-> DIAG_RESET)
		else $error("long sleep pulse ignored");
	a_reset_bridges: assert property (DIAG_RESET [*2] |-> s_off)
		else $error("bridges on in chip reset");
	a_standby_supply: assert property (SUPPLY_OFF == DIAG_RESET)
		else $error("supply state differs from reset");
	a_overheat_off: assert property (TEMP_ABOVE_HIGH |-> ##3 s_off)
		else $error("bridges on after overheat");
	a_read_answer: assert property (REG_RD && !DIAG_RESET |=> REG_RVALID)
		else $error("read not answered");
endmodule
bind dsp_stop_ctrl dsp_stop_ctrl_assertions #(.SLEEP_FILT_CYC(SLEEP_FILT_CYC)) u_chk (
	.CLK(CLK), .RST_N(RST_N), .SLEEP_PIN_N(SLEEP_PIN_N),
	.LEFT_REFERENCE_INPUT(LEFT_REFERENCE_INPUT), .RIGHT_REFERENCE_INPUT(RIGHT_REFERENCE_INPUT),
	.EXT_CLK_PRESENT(EXT_CLK_PRESENT), .TEMP_ABOVE_HIGH(TEMP_ABOVE_HIGH), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RVALID(REG_RVALID),
	.CLK_SEL_EXT(CLK_SEL_EXT), .BRIDGE_A_EN(BRIDGE_A_EN), .BRIDGE_B_EN(BRIDGE_B_EN),
	.DIAG_RESET(DIAG_RESET), .SUPPLY_OFF(SUPPLY_OFF), .OC_THRESHOLD_MA(OC_THRESHOLD_MA));
`default_nettype wire

// file: dsp_host_model.sv
// Host controller model: register accesses and control pins
`default_nettype none
module dsp_host_model (
	// Clock
	input  wire logic        clk,
	// Register port
	output var  logic        reg_wr,
	output var  logic        reg_rd,
	output var  logic [6:0]  reg_addr,
	output var  logic [31:0] reg_wdata,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_rvalid,
	// Pins
	output var  logic        sleep_n,
	output var  logic        ref_l,
	output var  logic        ref_r,
	output var  logic        ext_on
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{sleep_n, ref_l, ref_r, ext_on} = 4'h8;
	end
	// Idle bus shows the inverse so stale values never look valid
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic v);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1;
		v = reg_rvalid;
		d = reg_rdata;
	endtask
	// detector level stands for an in-range clock
	task automatic pins(input logic s, input logic l, input logic r, input logic e);
		@(posedge clk);
		{sleep_n, ref_l, ref_r, ext_on} <= {s, l, r, e};
	endtask
	// host turns the temperature code into degrees Celsius, rounded
	function automatic int celsius(input logic [7:0] c);
		return $rtoi(2.03 * c - 259.0 + 0.5);
	endfunction
	// clear quiescence, then enable in a separate write
	task automatic leave_stop;
		wr(7'h00, 32'h0000_4000);
		wr(7'h00, 32'h0000_0000);
	endtask
endmodule
`default_nettype wire

// file: dsp_stop_ctrl_tb_top.sv
// Self-checking bench for the stop/protection supervisor
`default_nettype none
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin err_total++; \
	$display("unexpected %s: expected %0h, seen %0h", nm, ex, ac); end end
module dsp_stop_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned FILT = 20;
	typedef struct packed {
		logic [6:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic [11:0] oc;
	} dsp_row_t;
	dsp_row_t rows [8] = '{
		'{7'h05, 32'h0, 32'h0, 12'h2EE}, '{7'h05, 32'h1, 32'h1, 12'h5DC},
		'{7'h05, 32'h2, 32'h2, 12'h8CA}, '{7'h05, 32'h73, 32'h73, 12'hBB8},
		'{7'h2F, 32'h0, 32'h0, 12'hBB8}, '{7'h2F, 32'h800, 32'h800, 12'hBB8},
		'{7'h10, 32'hFFFF_FFFF, 32'h0, 12'hBB8}, '{7'h6F, 32'h7, 32'h0, 12'hBB8}};
	logic clk = 1'b0;
	logic rst_n, slp_n, ref_l, ref_r, ext, csel, t_hi, t_lo, tval, schk;
	logic wr, rd, rval, br_a, br_b, enc, adc, sup, diag, v_ok, on;
	logic [1:0]  sdet;
	logic [7:0]  tcode;
	logic [6:0]  addr;
	logic [31:0] wdat, rdat, v;
	logic [11:0] oc;
	int err_total, compares;
	dsp_stop_ctrl #(.SLEEP_FILT_CYC(FILT)) u_dut (
		.CLK(clk), .RST_N(rst_n), .SLEEP_PIN_N(slp_n), .LEFT_REFERENCE_INPUT(ref_l),
		.RIGHT_REFERENCE_INPUT(ref_r), .EXT_CLK_PRESENT(ext), .CLK_SEL_EXT(csel),
		.TEMP_ABOVE_HIGH(t_hi), .TEMP_BELOW_LOW(t_lo), .TEMP_CODE(tcode), .TEMP_CODE_VALID(tval),
		.SHORT_DETECT(sdet), .SHORT_CHECK(schk), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wdat), .REG_RDATA(rdat), .REG_RVALID(rval), .BRIDGE_A_EN(br_a),
		.BRIDGE_B_EN(br_b), .ENCODER_EN(enc), .ADC_EN(adc), .SUPPLY_OFF(sup),
		.DIAG_RESET(diag), .OC_THRESHOLD_MA(oc));
	dsp_host_model u_host (
		.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdat),
		.reg_rdata(rdat), .reg_rvalid(rval), .sleep_n(slp_n), .ref_l(ref_l), .ref_r(ref_r),
		.ext_on(ext));
	always #2 clk = ~clk;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse_short(input logic [1:0] d);
		@(posedge clk);
		sdet <= d;
		schk <= 1'b1;
		@(posedge clk);
		schk <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("compares %0d, err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		give_verdict();
	end
	initial begin
		{rst_n, t_hi, t_lo, tval, schk, sdet, tcode} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		tick(2);
		`CHK("bridge", 1'b1, br_a)
		`CHK("encoder", 1'b1, enc)
		u_host.rd(7'h00, v, v_ok);
		`CHK("global_config", 32'h0, v)
		u_host.rd(7'h04, v, v_ok);
		`CHK("status", 32'h200, v & 32'h8201)
		foreach (rows[i]) begin
			u_host.wr(rows[i].a, rows[i].d);
			u_host.rd(rows[i].a, v, v_ok);
			`CHK("rdata", rows[i].q, v)
			`CHK("oc", rows[i].oc, oc)
		end
		for (int s = 0; s < 4; s++) begin
			u_host.wr(7'h05, 32'h13 | (s << 5));
			for (int p = 1; p < 4; p++) begin
				u_host.pins(1'b1, p[0], p[1], 1'b0);
				tick(6);
				on = !(s == 1 ? p[0] : s == 2 ? p[1] : p == 3);
				`CHK("hard stop", on, br_b)
				u_host.pins(1'b1, 1'b0, 1'b0, 1'b0);
				tick(6);
			end
		end
		u_host.pins(1'b1, 1'b0, 1'b0, 1'b1);
		tick(6);
		`CHK("clk sel", 1'b1, csel)
		u_host.wr(7'h00, 32'h8000);
		tick(3);
		`CHK("bridge", 1'b0, br_a)
		`CHK("clk sel", 1'b0, csel)
		`CHK("encoder", 1'b1, enc)
		u_host.rd(7'h04, v, v_ok);
		`CHK("qsc flag", 1'b1, v[15])
		u_host.rd(7'h05, v, v_ok);
		`CHK("kept", 32'h73, v)
		`CHK("rvalid", 1'b1, v_ok)
		u_host.wr(7'h2F, 32'h0);
		tick(1);
		`CHK("encoder", 1'b0, enc)
		u_host.wr(7'h2F, 32'h800);
		u_host.leave_stop();
		tick(3);
		`CHK("bridge", 1'b1, br_a)
		u_host.pins(1'b1, 1'b0, 1'b0, 1'b0);
		tick(6);
		`CHK("clk sel", 1'b0, csel)
		@(posedge clk);
		{tcode, tval, t_hi} <= {8'hA5, 2'b11};
		@(posedge clk);
		{tval, t_hi} <= 2'b00;
		tick(4);
		`CHK("bridges", 2'b00, {br_a, br_b})
		u_host.rd(7'h6F, v, v_ok);
		`CHK("overheat", 1'b1, v[0])
		u_host.rd(7'h04, v, v_ok);
		`CHK("temp", 8'hA5, v[8:1])
		`CHK("celsius", 76, u_host.celsius(v[8:1]))
		@(posedge clk);
		t_lo <= 1'b1;
		@(posedge clk);
		t_lo <= 1'b0;
		tick(4);
		`CHK("bridge", 1'b1, br_a)
		u_host.wr(7'h04, 32'h0);
		tick(1);
		`CHK("adc", 1'b0, adc)
		for (int k = 0; k < 7; k++)
			pulse_short(k == 3 ? 2'b00 : 2'b01);
		tick(2);
		`CHK("bridge", 1'b1, br_a)
		pulse_short(2'b01);
		tick(2);
		`CHK("bridges", 2'b01, {br_a, br_b})
		u_host.rd(7'h6F, v, v_ok);
		`CHK("short", 3'b010, v[2:0])
		u_host.leave_stop();
		tick(3);
		`CHK("bridge", 1'b1, br_a)
		repeat (4) pulse_short(2'b10);
		tick(2);
		`CHK("bridges", 2'b10, {br_a, br_b})
		u_host.rd(7'h6F, v, v_ok);
		`CHK("short", 3'b100, v[2:0])
		u_host.pins(1'b0, 1'b0, 1'b0, 1'b0);
		tick(FILT / 2);
		u_host.pins(1'b1, 1'b0, 1'b0, 1'b0);
		tick(6);
		`CHK("diag", 1'b0, diag)
		u_host.pins(1'b0, 1'b0, 1'b0, 1'b0);
		tick(FILT + 10);
		`CHK("diag sup br", 3'b110, {diag, sup, br_a})
		u_host.rd(7'h05, v, v_ok);
		`CHK("rvalid", 1'b0, v_ok)
		u_host.pins(1'b1, 1'b0, 1'b0, 1'b0);
		tick(8);
		u_host.rd(7'h05, v, v_ok);
		`CHK("defaults", 32'h3, v)
		give_verdict();
	end
endmodule
`default_nettype wire
